/* rtl/fpc_pkg.sv */
package fpc_pkg;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_HIGH_OFS   = 8'hf4;
  localparam logic [7:0] ADDR_LOW_OFS    = 8'hf5;
  localparam logic [7:0] WRITE_DATA_OFS  = 8'hf6;
  localparam logic [7:0] CONTROL_OFS     = 8'hf7;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_HIGH_RST   = 8'h00;
  localparam logic [7:0] ADDR_LOW_RST    = 8'h00;
  localparam logic [7:0] WRITE_DATA_RST  = 8'h00;
  localparam logic [7:0] CONTROL_RST     = 8'h00;

  // ----------------------------------------------------------------
  // Control field positions
  // ----------------------------------------------------------------
  localparam int START_BIT     = 7;
  localparam int PGSE_BIT      = 6;
  localparam int PGS_HI        = 5;
  localparam int PGS_LO        = 4;
  localparam int OPSEL_HI      = 1;
  localparam int OPSEL_LO      = 0;
  localparam logic [7:0] CONTROL_MASK = 8'hf3;

  // ----------------------------------------------------------------
  // Unlock sequence bytes
  // ----------------------------------------------------------------
  localparam logic [7:0] UNLOCK_FIRST  = 8'h55;
  localparam logic [7:0] UNLOCK_SECOND = 8'haa;
  localparam logic [7:0] UNLOCK_THIRD  = 8'h55;

  // ----------------------------------------------------------------
  // Page sizes and service region
  // ----------------------------------------------------------------
  localparam logic [9:0]  PAGE_512      = 10'h200;
  localparam logic [9:0]  PAGE_256      = 10'h100;
  localparam logic [9:0]  PAGE_128      = 10'h080;
  localparam logic [2:0]  PAGE_CODE_256 = 3'h5;
  localparam logic [2:0]  PAGE_CODE_128 = 3'h6;
  localparam logic [2:0]  PAGE_CODE_RSV = 3'h7;
  localparam logic [16:0] SERVICE_BLOCK = 17'h00200;
  localparam logic [16:0] FLASH_END     = 17'h10000;

  typedef enum logic [1:0] {
    OP_BYTE_PROGRAM = 2'b00,
    OP_CHIP_PROTECT = 2'b01,
    OP_PAGE_ERASE   = 2'b10,
    OP_CHIP_ERASE   = 2'b11
  } fpc_op_e;

  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_ISSUE = 2'b01,
    ST_WAIT  = 2'b10
  } fpc_state_e;

endpackage : fpc_pkg

/* rtl/fpc_unlock.sv */
`timescale 1ns/1ps
module fpc_unlock (
  // Clock and reset
  input  wire logic       mclk,
  input  wire logic       rst_n,
  // Data register writes
  input  wire logic       data_we,
  input  wire logic [7:0] data_wdata,
  // Relock request
  input  wire logic       relock,
  // Status
  output logic            unlocked
);

  typedef struct packed {
    logic [1:0] step;
    logic       open;
  } fpc_unlock_s;

  fpc_unlock_s st_r;
  fpc_unlock_s st_nxt;

  // ----------------------------------------------------------------
  // Sequence tracking
  // ----------------------------------------------------------------
  always_comb begin
    st_nxt = st_r;
    if (relock) begin
      st_nxt = '0;
    end else if (data_we && !st_r.open) begin
      unique case (st_r.step)
        2'd0: st_nxt.step = (data_wdata == fpc_pkg::UNLOCK_FIRST)
                            ? 2'd1 : 2'd0;
        2'd1: st_nxt.step = (data_wdata == fpc_pkg::UNLOCK_SECOND)
                            ? 2'd2 : 2'd0;
        2'd2: begin
          if (data_wdata == fpc_pkg::UNLOCK_THIRD) begin
            st_nxt.open = 1'b1;
            st_nxt.step = 2'd0;
          end else begin
            st_nxt.step = 2'd0;
          end
        end
        default: st_nxt.step = 2'd0;
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign unlocked = st_r.open;

endmodule : fpc_unlock

/* rtl/fpc_flash_ctrl.sv */
`timescale 1ns/1ps
// How it works
// - Start bit one launches selected operation; start zero does nothing.
// - Enable and page-select code give 512, 256 or 128 byte pages; code 111 gives none and page erase does nothing.
// - Select 00 program, 01 protect, 10 page erase, 11 chip erase.
// - Operation starts straight from the control register write.
// - Page erase clears the whole page holding the target address.
// - Chip erase clears everything except the service-program region.
// - After protect, flash reads return zero.
// - Interrupts arriving during an operation are dropped.
// - Target address is high register over low register, 16 bits.
// - Program or page erase into service region changes nothing.
// - Eight-bit data register holds the byte to program.
module fpc_flash_ctrl #(
  parameter int SERVICE_BLOCKS = 8
) (
  // Clock and reset
  input  wire logic        mclk,
  input  wire logic        rst_n,
  // Register port
  input  wire logic [7:0]  sfr_addr,
  input  wire logic        sfr_we,
  input  wire logic        sfr_re,
  input  wire logic [7:0]  sfr_wdata,
  output logic      [7:0]  sfr_rdata,
  // System configuration enable
  input  wire logic        self_program_write_permit,
  // Flash array command
  output logic             flash_cmd_valid,
  output logic      [1:0]  flash_cmd_op,
  output logic      [15:0] flash_cmd_addr,
  output logic      [9:0]  flash_cmd_page_bytes,
  output logic      [7:0]  flash_write_data,
  output logic      [15:0] flash_erase_limit,
  input  wire logic        flash_busy,
  // Flash read path
  input  wire logic [7:0]  flash_rd_raw,
  output logic      [7:0]  flash_rd_data,
  // Interrupt path
  input  wire logic        irq_in,
  output logic             irq_out,
  // Status
  output logic             op_active
);

  typedef struct packed {
    fpc_pkg::fpc_state_e state;
    logic [7:0]          addr_hi;
    logic [7:0]          addr_lo;
    logic [7:0]          wdata;
    logic [7:0]          ctrl;
    logic                protect;
    logic [7:0]          rdata;
    logic [1:0]          op;
    logic [15:0]         addr;
    logic [9:0]          page;
    logic                permit_d;
  } fpc_ctrl_s;

  fpc_ctrl_s st_r;
  fpc_ctrl_s st_nxt;
  logic      unlocked;
  logic      data_we;
  logic      ctrl_we;
  logic      launch;
  logic [15:0] tgt_addr;
  logic [9:0]  page_bytes;
  logic        in_service;
  logic [16:0] service_base;
  logic        relock;

  function automatic logic [9:0] page_size(input logic [2:0] code);
    unique case (code)
      fpc_pkg::PAGE_CODE_256: page_size = fpc_pkg::PAGE_256;
      fpc_pkg::PAGE_CODE_128: page_size = fpc_pkg::PAGE_128;
      fpc_pkg::PAGE_CODE_RSV: page_size = 10'h000;
      default:                page_size = fpc_pkg::PAGE_512;
    endcase
  endfunction : page_size

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  assign data_we  = sfr_we && (sfr_addr == fpc_pkg::WRITE_DATA_OFS);
  assign ctrl_we  = sfr_we && (sfr_addr == fpc_pkg::CONTROL_OFS);
  assign tgt_addr = {st_r.addr_hi, st_r.addr_lo};
  assign page_bytes = page_size({sfr_wdata[fpc_pkg::PGSE_BIT],
                     sfr_wdata[fpc_pkg::PGS_HI:fpc_pkg::PGS_LO]});
  assign service_base = fpc_pkg::FLASH_END -
         17'(fpc_pkg::SERVICE_BLOCK * 17'(SERVICE_BLOCKS));
  assign in_service = (SERVICE_BLOCKS != 0) &&
                      ({1'b0, tgt_addr} >= service_base);
  assign launch = ctrl_we && sfr_wdata[fpc_pkg::START_BIT] &&
                  unlocked && self_program_write_permit &&
                  (st_r.state == fpc_pkg::ST_IDLE);
  // Unlock survives a low enable; only its falling edge drops it
  assign relock = st_r.permit_d && !self_program_write_permit;

  fpc_unlock u_unlock (
    .mclk       (mclk),
    .rst_n      (rst_n),
    .data_we    (data_we),
    .data_wdata (sfr_wdata),
    .relock     (relock),
    .unlocked   (unlocked)
  );

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    st_nxt = st_r;
    st_nxt.permit_d = self_program_write_permit;
    if (sfr_we) begin
      unique case (sfr_addr)
        fpc_pkg::ADDR_HIGH_OFS:  st_nxt.addr_hi = sfr_wdata;
        fpc_pkg::ADDR_LOW_OFS:   st_nxt.addr_lo = sfr_wdata;
        fpc_pkg::WRITE_DATA_OFS: st_nxt.wdata   = sfr_wdata;
        fpc_pkg::CONTROL_OFS: begin
          if (st_r.state == fpc_pkg::ST_IDLE) begin
            st_nxt.ctrl = sfr_wdata & fpc_pkg::CONTROL_MASK;
            st_nxt.ctrl[fpc_pkg::START_BIT] = launch;
          end
        end
        default: ;
      endcase
    end
    if (sfr_re) begin
      unique case (sfr_addr)
        fpc_pkg::ADDR_HIGH_OFS:  st_nxt.rdata = st_r.addr_hi;
        fpc_pkg::ADDR_LOW_OFS:   st_nxt.rdata = st_r.addr_lo;
        fpc_pkg::WRITE_DATA_OFS: st_nxt.rdata = st_r.wdata;
        fpc_pkg::CONTROL_OFS:    st_nxt.rdata = st_r.ctrl;
        default:                 st_nxt.rdata = 8'h00;
      endcase
    end
    unique case (st_r.state)
      fpc_pkg::ST_IDLE: begin
        if (launch) begin
          st_nxt.op   = sfr_wdata[fpc_pkg::OPSEL_HI:fpc_pkg::OPSEL_LO];
          st_nxt.page = page_bytes;
          st_nxt.addr = tgt_addr;
          st_nxt.state = fpc_pkg::ST_ISSUE;
          unique case (fpc_pkg::fpc_op_e'(st_nxt.op))
            fpc_pkg::OP_BYTE_PROGRAM: begin
              if (in_service) begin
                st_nxt.state = fpc_pkg::ST_IDLE;
              end
            end
            fpc_pkg::OP_PAGE_ERASE: begin
              st_nxt.addr = tgt_addr &
                            ~{6'h00, page_bytes - 10'h001};
              if (in_service || page_bytes == 10'h000) begin
                st_nxt.state = fpc_pkg::ST_IDLE;
              end
            end
            fpc_pkg::OP_CHIP_PROTECT: st_nxt.addr = 16'h0000;
            fpc_pkg::OP_CHIP_ERASE:   st_nxt.addr = 16'h0000;
          endcase
          if (st_nxt.state == fpc_pkg::ST_IDLE) begin
            st_nxt.ctrl[fpc_pkg::START_BIT] = 1'b0;
          end
        end
      end
      fpc_pkg::ST_ISSUE: st_nxt.state = fpc_pkg::ST_WAIT;
      fpc_pkg::ST_WAIT: begin
        if (!flash_busy) begin
          st_nxt.state = fpc_pkg::ST_IDLE;
          st_nxt.ctrl[fpc_pkg::START_BIT] = 1'b0;
          if (st_r.op == fpc_pkg::OP_CHIP_PROTECT) begin
            st_nxt.protect = 1'b1;
          end
        end
      end
      default: st_nxt.state = fpc_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      st_r.state   <= fpc_pkg::ST_IDLE;
      st_r.addr_hi <= fpc_pkg::ADDR_HIGH_RST;
      st_r.addr_lo <= fpc_pkg::ADDR_LOW_RST;
      st_r.wdata   <= fpc_pkg::WRITE_DATA_RST;
      st_r.ctrl    <= fpc_pkg::CONTROL_RST;
      st_r.protect <= 1'b0;
      st_r.rdata   <= 8'h00;
      st_r.op      <= 2'b00;
      st_r.addr    <= 16'h0000;
      st_r.page    <= 10'h000;
      st_r.permit_d <= 1'b0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign sfr_rdata            = st_r.rdata;
  assign flash_cmd_valid      = (st_r.state == fpc_pkg::ST_ISSUE);
  assign flash_cmd_op         = st_r.op;
  assign flash_cmd_addr       = st_r.addr;
  assign flash_cmd_page_bytes = st_r.page;
  assign flash_write_data     = st_r.wdata;
  assign flash_erase_limit    = 16'(service_base - 17'h00001);
  assign flash_rd_data = st_r.protect ? 8'h00 : flash_rd_raw;
  assign op_active     = (st_r.state != fpc_pkg::ST_IDLE);
  assign irq_out       = irq_in && !op_active;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  a_start_launch: assert property (
    @(posedge mclk) disable iff (!rst_n)
    launch && sfr_wdata[1] == 1'b0 && !in_service |=>
    flash_cmd_valid ##1 !flash_cmd_valid)
    else $error("launch did not issue one command");
  a_locked_ignore: assert property (
    @(posedge mclk) disable iff (!rst_n)
    ctrl_we && (!unlocked || !self_program_write_permit) &&
    !op_active |=> (!op_active) [*2])
    else $error("locked write started an operation");
  a_permit_relock: assert property (
    @(posedge mclk) disable iff (!rst_n)
    st_r.permit_d && !self_program_write_permit |=> !unlocked)
    else $error("unlock kept after enable fell");
  a_zero_start: assert property (
    @(posedge mclk) disable iff (!rst_n)
    ctrl_we && !sfr_wdata[7] && !op_active |=> !flash_cmd_valid)
    else $error("start zero issued a command");
  a_page_256: assert property (
    @(posedge mclk) disable iff (!rst_n)
    launch && sfr_wdata[6:4] == 3'h5 && sfr_wdata[1:0] == 2'b10 &&
    !in_service |=> flash_cmd_page_bytes == 10'h100 &&
    flash_cmd_addr[7:0] == 8'h00)
    else $error("page erase size or base wrong");
  a_addr_join: assert property (
    @(posedge mclk) disable iff (!rst_n)
    launch && sfr_wdata[1:0] == 2'b00 && !in_service |=>
    flash_cmd_addr == $past(tgt_addr))
    else $error("program address not high over low");
  a_service_guard: assert property (
    @(posedge mclk) disable iff (!rst_n)
    launch && in_service && !sfr_wdata[0] |=> !op_active ##1
    !flash_cmd_valid)
    else $error("service region write was issued");
  a_protect_zero: assert property (
    @(posedge mclk) disable iff (!rst_n)
    st_r.state == fpc_pkg::ST_WAIT && !flash_busy &&
    st_r.op == 2'b01 |=> (flash_rd_data == 8'h00) [*3])
    else $error("protected read returned data");
  a_irq_drop: assert property (
    @(posedge mclk) disable iff (!rst_n)
    flash_cmd_valid |-> !irq_out ##1 !irq_out)
    else $error("interrupt passed during operation");
  a_data_hold: assert property (
    @(posedge mclk) disable iff (!rst_n)
    data_we |=> flash_write_data == $past(sfr_wdata))
    else $error("data register did not load");

endmodule : fpc_flash_ctrl

/* test/fpc_flash_model.sv */
`timescale 1ns/1ps
module fpc_flash_model (
  // Clock and reset
  input  wire logic       mclk,
  input  wire logic       rst_n,
  // Command from controller
  input  wire logic       flash_cmd_valid,
  input  wire logic [7:0] lat,
  // Array status
  output logic            flash_busy,
  output logic      [7:0] flash_rd_raw,
  output logic      [7:0] cmd_cnt
);
  // ----------------------------------------------------------------
  // Busy timing, zero latency answers at once
  // ----------------------------------------------------------------
  logic [7:0] left_r;
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      flash_busy <= 1'b0;
      left_r     <= 8'h00;
      cmd_cnt    <= 8'h00;
    end else if (flash_cmd_valid) begin
      cmd_cnt    <= cmd_cnt + 8'h01;
      flash_busy <= (lat != 8'h00);
      left_r     <= lat;
    end else if (left_r > 8'h01) begin
      left_r     <= left_r - 8'h01;
    end else begin
      flash_busy <= 1'b0;
      left_r     <= 8'h00;
    end
  end
  assign flash_rd_raw = {4'ha, cmd_cnt[3:0]};
endmodule : fpc_flash_model

/* test/testbench.sv */
`timescale 1ns/1ps
module testbench;
  logic        mclk, rst_n, sfr_we, sfr_re, permit, irq_in;
  logic [7:0]  sfr_addr, sfr_wdata, lat, cmd_cnt, raw, rdata, rdv;
  logic [7:0]  flash_rd_data, wd, c_wd;
  logic        flash_cmd_valid, flash_busy, irq_out, op_active;
  logic [1:0]  cmd_op, c_op;
  logic [15:0] cmd_addr, lim, c_addr, c_lim;
  logic [9:0]  pb, c_pb;
  int          failures, n_tests;

  fpc_flash_ctrl #(.SERVICE_BLOCKS(2)) dut_u (
    .mclk(mclk), .rst_n(rst_n), .sfr_addr(sfr_addr), .sfr_we(sfr_we),
    .sfr_re(sfr_re), .sfr_wdata(sfr_wdata), .sfr_rdata(rdata),
    .self_program_write_permit(permit), .flash_cmd_valid(flash_cmd_valid),
    .flash_cmd_op(cmd_op), .flash_cmd_addr(cmd_addr),
    .flash_cmd_page_bytes(pb), .flash_write_data(wd),
    .flash_erase_limit(lim), .flash_busy(flash_busy),
    .flash_rd_raw(raw), .flash_rd_data(flash_rd_data),
    .irq_in(irq_in), .irq_out(irq_out), .op_active(op_active));

  fpc_flash_model fm_u (
    .mclk(mclk), .rst_n(rst_n), .flash_cmd_valid(flash_cmd_valid),
    .lat(lat), .flash_busy(flash_busy), .flash_rd_raw(raw),
    .cmd_cnt(cmd_cnt));

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task give_verdict;
    if (failures == 0 && n_tests > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : give_verdict

  task chk(input logic [15:0] got, input logic [15:0] exp, input string m);
    n_tests++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask : chk

  task wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge mclk);
    sfr_addr  = a;
    sfr_wdata = d;
    sfr_we    = 1'b1;
    @(negedge mclk);
    sfr_we    = 1'b0;
  endtask : wr

  task rd(input logic [7:0] a);
    @(negedge mclk);
    sfr_addr = a;
    sfr_re   = 1'b1;
    @(negedge mclk);
    sfr_re   = 1'b0;
    rdv      = rdata;
  endtask : rd

  task launch(input logic [7:0] c, input logic go);
    int n;
    logic [7:0] cnt0;
    cnt0 = cmd_cnt;
    wr(fpc_pkg::CONTROL_OFS, c);
    chk(flash_cmd_valid, go, "command pulse");
    c_op   = cmd_op;
    c_addr = cmd_addr;
    c_pb   = pb;
    c_wd   = wd;
    c_lim  = lim;
    if (go) chk(irq_out, 1'b0, "irq during op");
    n = 0;
    while (op_active !== 1'b0 && n < 100) begin
      @(negedge mclk);
      n++;
    end
    chk(n < 100, 1'b1, "op never ends");
    chk(irq_out, 1'b1, "irq when idle");
    chk(cmd_cnt - cnt0, go, "command count");
    rd(fpc_pkg::CONTROL_OFS);
    chk(rdv, c & 8'h73, "control readback");
  endtask : launch

  task unlock;
    wr(fpc_pkg::WRITE_DATA_OFS, 8'h55);
    wr(fpc_pkg::WRITE_DATA_OFS, 8'haa);
    wr(fpc_pkg::WRITE_DATA_OFS, 8'h55);
  endtask : unlock

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task t_reset;
    logic [7:0] a;
    for (int i = 0; i < 5; i++) begin
      a = (i == 4) ? 8'h80 : 8'hf4 + i[7:0];
      rd(a);
      chk(rdv, 8'h00, "reset value");
    end
  endtask : t_reset

  task t_lock;
    launch(8'h80, 1'b0);
    wr(fpc_pkg::WRITE_DATA_OFS, 8'h55);
    wr(fpc_pkg::WRITE_DATA_OFS, 8'haa);
    wr(fpc_pkg::WRITE_DATA_OFS, 8'h12);
    wr(fpc_pkg::WRITE_DATA_OFS, 8'h55);
    launch(8'h80, 1'b0);
    wr(fpc_pkg::WRITE_DATA_OFS, 8'h00);
    unlock();
    permit = 1'b0;
    launch(8'h80, 1'b0);
    permit = 1'b1;
    launch(8'h80, 1'b0);
    // Unlock while enable is low, then enable
    permit = 1'b0;
    unlock();
    permit = 1'b1;
  endtask : t_lock

  task t_program;
    wr(fpc_pkg::ADDR_HIGH_OFS, 8'h10);
    wr(fpc_pkg::ADDR_LOW_OFS, 8'h05);
    wr(fpc_pkg::WRITE_DATA_OFS, 8'h22);
    launch(8'h02, 1'b0);
    launch(8'h80, 1'b1);
    chk(c_op, 2'b00, "program op");
    chk(c_addr, 16'h1005, "program addr");
    chk(c_wd, 8'h22, "program data");
    rd(fpc_pkg::WRITE_DATA_OFS);
    chk(rdv, 8'h22, "data readback");
  endtask : t_program

  task t_pages;
    logic [9:0] sz;
    wr(fpc_pkg::ADDR_HIGH_OFS, 8'h12);
    wr(fpc_pkg::ADDR_LOW_OFS, 8'hf7);
    for (int i = 0; i < 8; i++) begin
      lat = i[0] ? 8'h00 : 8'h14;
      sz  = (i == 5) ? 10'h100 : (i == 6) ? 10'h080 : 10'h200;
      launch(8'h82 | {1'b0, i[2:0], 4'h0}, i != 7);
      if (i != 7) begin
        chk(c_op, 2'b10, "erase op");
        chk(c_pb, sz, "page size");
        chk(c_addr, (i == 6) ? 16'h1280 : 16'h1200, "page base");
      end
    end
  endtask : t_pages

  task t_chip_and_service;
    launch(8'h83, 1'b1);
    chk(c_op, 2'b11, "chip erase op");
    chk(c_lim, 16'hfbff, "erase limit");
    wr(fpc_pkg::ADDR_HIGH_OFS, 8'hfe);
    wr(fpc_pkg::ADDR_LOW_OFS, 8'h10);
    launch(8'h80, 1'b0);
    launch(8'h82, 1'b0);
  endtask : t_chip_and_service

  task t_protect;
    chk(flash_rd_data, raw, "read before protect");
    launch(8'h81, 1'b1);
    chk(c_op, 2'b01, "protect op");
    chk(flash_rd_data, 8'h00, "read after protect");
  endtask : t_protect

  task t_rearm;
    irq_in = 1'b0;
    @(negedge mclk);
    chk(irq_out, 1'b0, "irq follows input");
    irq_in = 1'b1;
    rst_n  = 1'b0;
    repeat (3) @(negedge mclk);
    rst_n  = 1'b1;
    t_reset();
    chk(flash_rd_data, raw, "protect cleared by reset");
    launch(8'h81, 1'b0);
  endtask : t_rearm

  // ----------------------------------------------------------------
  // Clock, reset, sequence and watchdog
  // ----------------------------------------------------------------
  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end

  initial begin
    failures  = 0;
    n_tests   = 0;
    rst_n     = 1'b0;
    sfr_addr  = 8'h00;
    sfr_wdata = 8'h00;
    sfr_we    = 1'b0;
    sfr_re    = 1'b0;
    permit    = 1'b1;
    irq_in    = 1'b1;
    lat       = 8'h06;
    repeat (3) @(negedge mclk);
    rst_n = 1'b1;
    t_reset();
    t_lock();
    t_program();
    t_pages();
    t_chip_and_service();
    t_protect();
    t_rearm();
    give_verdict();
  end

  initial begin
    #250000;
    failures++;
    give_verdict();
  end
endmodule : testbench
